//--- src/atc_top.sv
// Purpose: transmit configuration word register and negotiation control
// Assumes: simple synchronous register port, one access per cycle
// Notes: EEPROM straps sampled in the first cycle after reset release
`timescale 1ns/100ps
module atc_top #(
    // Address bits decoded on the register port
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // EEPROM straps and mode
    input wire logic [15:0] eeprom_word_bits,
    input wire logic eeprom_hw_enable,
    input wire logic serdes_mode,
    // Receiver and negotiation engine
    input wire logic rx_sync,
    input wire logic an_sending_config,
    output logic an_restart,
    // Toward PCS
    output logic [1:0] tx_kind,
    output logic [15:0] tx_config_word
);
    // Released reset chain
    logic rst_m_q;
    logic rst_q;

    // Programmed state
    logic strap_done_d;
    logic strap_done_q;
    logic [15:0] word_d;
    logic [15:0] word_q;
    logic en_d;
    logic en_q;
    logic sel_d;
    logic sel_q;

    // Restart pulse
    logic sync_prev_d;
    logic sync_prev_q;
    logic restart_d;
    logic restart_q;

    // Read answer
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;

    // Bundle toward the transmit content selector
    atc_if bus ();

    // Offset needs twelve address bits; a narrower port would alias it
    if (ADDR_W < 12 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("atc_top: ADDR_W must lie between 12 and 32");
    end

    // Selector and PCS side assume a sixteen-bit word
    if (atc_pkg::ATC_WORD_W != 16)
    begin : g_word_w_check
        $error("atc_top: configuration word must be 16 bits wide");
    end

    // Register decode, shared by the write and read paths
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        return addr == ADDR_W'(atc_pkg::ATC_OFFSET);
    endfunction : addr_hit

    // Mapped write, taken only once the straps are in
    function automatic logic take_write(input logic wr, input logic done,
        input logic [ADDR_W-1:0] addr);
        return wr && done && addr_hit(addr);
    endfunction : take_write

    // Only strapped bits survive; the rest of the word stays clear
    function automatic logic [15:0] strap_word(input logic [15:0] bits);
        return bits & atc_pkg::ATC_STRAP_MASK;
    endfunction : strap_word

    // Loss-to-sync transition on the receiver status
    function automatic logic sync_regained(input logic prev,
        input logic now_sync);
        return now_sync && !prev;
    endfunction : sync_regained

    // Read layout: enable, select, zeros in 29:16, then the word
    function automatic logic [31:0] pack_read(input logic en,
        input logic sel, input logic [15:0] word);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[atc_pkg::ATC_BIT_HW_EN] = en;
        r[atc_pkg::ATC_BIT_SEL] = sel;
        r[15:0] = word;
        return r;
    endfunction : pack_read

    // Reset release through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    // Config next values; strap load wins over a same-cycle write
    always_comb
    begin
        strap_done_d = 1'b1;
        word_d = word_q;
        en_d = en_q;
        sel_d = sel_q;
        if (!strap_done_q)
        begin
            word_d = strap_word(eeprom_word_bits);
            en_d = eeprom_hw_enable;
        end
        else if (take_write(reg_wr, strap_done_q, reg_addr))
        begin
            // Word stored verbatim so readback matches the write
            word_d = reg_wdata[15:0];
            en_d = reg_wdata[atc_pkg::ATC_BIT_HW_EN];
            sel_d = reg_wdata[atc_pkg::ATC_BIT_SEL];
        end
    end

    // Word clears at reset, fields then set by straps or writes
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            strap_done_q <= 1'b0;
            word_q <= atc_pkg::ATC_WORD_RESET;
            en_q <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            strap_done_q <= strap_done_d;
            word_q <= word_d;
            en_q <= en_d;
            sel_q <= sel_d;
        end
    end

    // Restart pulse: a write of one to the enable, or regained sync while enabled
    always_comb
    begin
        sync_prev_d = rx_sync;
        restart_d = 1'b0;
        if (take_write(reg_wr, strap_done_q, reg_addr))
            restart_d = reg_wdata[atc_pkg::ATC_BIT_HW_EN];
        // Resync while enabled also restarts
        if (en_q && sync_regained(sync_prev_q, rx_sync))
            restart_d = 1'b1;
    end

    // Previous sync resets high so a synced link gives no false edge
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            sync_prev_q <= 1'b1;
            restart_q <= 1'b0;
        end
        else
        begin
            sync_prev_q <= sync_prev_d;
            restart_q <= restart_d;
        end
    end

    // Read data: bits 29:16 and unmapped reads return zero
    always_comb
    begin
        rvalid_d = reg_rd;
        rdata_d = 32'h0000_0000;
        if (reg_rd && addr_hit(reg_addr))
            rdata_d = pack_read(en_q, sel_q, word_q);
    end

    // Read answer stands for one cycle after the strobe
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Field layout passes unchanged to the PCS; reserved bits not masked
    assign bus.word = word_q;
    assign bus.hw_negotiation_enable = en_q;
    assign bus.send_ordered_set_select = sel_q;
    assign bus.serdes_mode = serdes_mode;

    atc_tx_select u_sel (
        .clk(clk),
        .rst_n(rst_q),
        .cfg(bus),
        .an_sending_config(an_sending_config),
        .tx_kind(tx_kind),
        .tx_config_word(tx_config_word)
    );

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign an_restart = restart_q;
endmodule : atc_top

//--- src/atc_pkg.sv
// Purpose: constants for the autoneg transmit configuration block
// Assumes: 32-bit register access at one documented offset
// Notes: reset values of bits 5, 7, 8, 31 come from the EEPROM straps
//
// How it works
// - Register acts only in SerDes mode; here writes, reads and restart act in any mode.
// - Hardware mode sends word as /C/ sets.
// - Software mode: select bit picks /C/ or idle.
// - Sixteen-bit word clears at reset.
// - Readback equals last write; sync loss leaves it.
// - Fields: next page, fault, half, full duplex.
// - Bits 14 and 4:0 reserved, write zero.
// - Bits 5, 7, 8 loaded from EEPROM.
// - Bit 31 enables; writing one restarts.
// - Bit 30 selects /C/ sets or idle.
// - Resync restarts negotiation when enabled.
package atc_pkg;
    localparam logic [11:0] ATC_OFFSET = 12'h178;
    localparam int ATC_WORD_W = 16;
    localparam int ATC_BIT_HW_EN = 31;
    localparam int ATC_BIT_SEL = 30;
    localparam int ATC_BIT_FULL = 5;
    localparam int ATC_BIT_PAUSE_SYM = 7;
    localparam int ATC_BIT_PAUSE_ASYM = 8;
    localparam int ATC_BIT_NEXT_PAGE = 15;
    localparam int ATC_BIT_RSVD14 = 14;
    localparam logic [15:0] ATC_WORD_RESET = 16'h0000;
    localparam logic [15:0] ATC_STRAP_MASK = 16'h01a0;
    localparam logic [15:0] ATC_RSVD_MASK = 16'h401f;
    // Content selector toward the transmit PCS
    typedef enum logic [1:0]
    {
        ATC_TX_IDLE = 2'b00,
        ATC_TX_CONFIG = 2'b01
    } atc_tx_e;
endpackage : atc_pkg

//--- src/atc_if.sv
// Purpose: bundle between register file and transmit content selector
// Assumes: one clock domain
// Notes: carries the programmed fields and the SerDes mode input
`timescale 1ns/100ps
interface atc_if;
    logic [15:0] word;
    logic hw_negotiation_enable;
    logic send_ordered_set_select;
    logic serdes_mode;
    modport ctrl (output word, hw_negotiation_enable,
        send_ordered_set_select, serdes_mode);
    modport sel (input word, hw_negotiation_enable,
        send_ordered_set_select, serdes_mode);
endinterface : atc_if

//--- src/atc_tx_select.sv
// Purpose: picks what the transmit PCS sends and the word it carries
// Assumes: PCS encodes the 16-bit word as two 10-bit code-groups
// Notes: outputs registered
`timescale 1ns/100ps
module atc_tx_select (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fields from the register
    atc_if.sel cfg,
    // Hardware negotiation wants /C/ sets
    input wire logic an_sending_config,
    // Toward PCS
    output logic [1:0] tx_kind,
    output logic [15:0] tx_config_word
);
    logic [1:0] kind_d;
    logic [1:0] kind_q;
    logic [15:0] word_d;
    logic [15:0] word_q;

    // Mode decode; tx_kind held idle outside SerDes mode, word still driven
    always_comb
    begin
        kind_d = atc_pkg::ATC_TX_IDLE;
        word_d = cfg.word;
        if (!cfg.serdes_mode)
            kind_d = atc_pkg::ATC_TX_IDLE;
        else if (cfg.hw_negotiation_enable)
            kind_d = an_sending_config ? atc_pkg::ATC_TX_CONFIG
                : atc_pkg::ATC_TX_IDLE;
        else if (cfg.send_ordered_set_select)
            kind_d = atc_pkg::ATC_TX_CONFIG;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_q <= atc_pkg::ATC_TX_IDLE;
            word_q <= atc_pkg::ATC_WORD_RESET;
        end
        else
        begin
            kind_q <= kind_d;
            word_q <= word_d;
        end
    end

    assign tx_kind = kind_q;
    assign tx_config_word = word_q;
endmodule : atc_tx_select

//--- tb/atc_assertions.sv
// Purpose: port checks for atc_top
// Assumes: single clock, bench writes after strap cycle
// Notes: bound below
`timescale 1ns/100ps
module atc_assertions (
    // Watched ports
    input logic clk,
    input logic arst_n,
    input logic reg_wr,
    input logic reg_rd,
    input logic [11:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_rvalid,
    input logic serdes_mode,
    input logic an_sending_config,
    input logic an_restart,
    input logic [1:0] tx_kind,
    input logic [15:0] tx_config_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Mapped write; mode checks need two quiet cycles
    logic hit;
    assign hit = reg_wr && reg_addr == 12'h178;
    sequence s_q; (!reg_wr && serdes_mode) [*2]; endsequence
    property p_rv; reg_rd |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_nrv; !reg_rd |=> !reg_rvalid; endproperty
    a_nrv: assert property (p_nrv) else $error("stray valid");
    property p_rs; hit && reg_wdata[31] |=> an_restart; endproperty
    a_rs: assert property (p_rs) else $error("no restart");
    property p_wd;
        hit ##1 !reg_wr |=> tx_config_word == $past(reg_wdata[15:0], 2);
    endproperty
    a_wd: assert property (p_wd) else $error("word not sent");
    property p_phy; !serdes_mode [*3] |-> tx_kind == 2'b00; endproperty
    a_phy: assert property (p_phy) else $error("sends in phy mode");
    property p_sel;
        hit && serdes_mode && reg_wdata[31:30] == 2'b01 ##1 s_q
            |-> tx_kind == 2'b01;
    endproperty
    a_sel: assert property (p_sel) else $error("select ignored");
    property p_sw;
        hit && serdes_mode && reg_wdata[31:30] == 2'b00 ##1 s_q
            |-> tx_kind == 2'b00;
    endproperty
    a_sw: assert property (p_sw) else $error("idle not sent");
    property p_hw;
        hit && serdes_mode && an_sending_config && reg_wdata[31:30] == 2'b10
            ##1 (!reg_wr && serdes_mode && an_sending_config) [*2]
            |-> tx_kind == 2'b01;
    endproperty
    a_hw: assert property (p_hw) else $error("engine ignored");
    c_rs: cover property (an_restart);
    c_cfg: cover property (tx_kind == 2'b01);
    c_rd: cover property (reg_rvalid);
endmodule : atc_assertions
bind atc_top atc_assertions u_chk (.clk(clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
    .serdes_mode(serdes_mode), .an_sending_config(an_sending_config),
    .an_restart(an_restart), .tx_kind(tx_kind),
    .tx_config_word(tx_config_word));

//--- tb/atc_partner.sv
// Purpose: link partner and engine stand-in
// Assumes: bench commands sync loss
// Notes: posedge update avoids racing bench
`timescale 1ns/100ps
module atc_partner (
    // Clock and bench commands
    input logic clk,
    input logic drop,
    input logic want,
    // Toward device
    output logic rx_sync = 1'b1,
    output logic an_sending_config = 1'b0
);
    // Sync loss and config requests
    always @(posedge clk)
    begin
        rx_sync <= !drop;
        an_sending_config <= want;
    end
endmodule : atc_partner

//--- tb/atc_top_tb_top.sv
// Purpose: bench for atc_top
// Assumes: straps all set
// Notes: random words from lfsr seeded 25
`timescale 1ns/100ps
module atc_top_tb_top;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, serdes_mode = 1;
    logic drop = 0, want = 0, eeprom_hw_enable = 1, rx_sync;
    logic an_sending_config, an_restart, reg_rvalid;
    logic [11:0] reg_addr = 12'h178;
    logic [31:0] reg_wdata = 0, reg_rdata, lfsr = 32'h19, sh;
    logic [15:0] eeprom_word_bits = 16'h01b9, tx_config_word;
    logic [1:0] tx_kind;
    int error_cnt = 0, n_tests = 0, cyc = 0, k;
    always #12.5 clk = ~clk;
    atc_top u_atc_top (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .eeprom_word_bits(eeprom_word_bits),
        .eeprom_hw_enable(eeprom_hw_enable), .serdes_mode(serdes_mode),
        .rx_sync(rx_sync), .an_sending_config(an_sending_config),
        .an_restart(an_restart), .tx_kind(tx_kind),
        .tx_config_word(tx_config_word));
    atc_partner u_atc_partner (.clk(clk), .drop(drop), .want(want),
        .rx_sync(rx_sync), .an_sending_config(an_sending_config));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // Expected content: phy idles, hw follows engine, sw uses select
    function automatic logic [1:0] ek(input logic [31:0] r, input logic s, a);
        return (s && (r[31] ? a : r[30])) ? 2'b01 : 2'b00;
    endfunction : ek
    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (e !== g)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge clk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 0;
        chk("rdata", e, reg_rdata);
        chk("rvalid", 32'h1, 32'(reg_rvalid));
    endtask : rd
    // Hang guard, run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(negedge clk);
        arst_n = 1;
        repeat (4) @(negedge clk);
        rd(12'h178, 32'h8000_01a0);
        rd(12'h17c, 32'h0);
        wr(12'h17c, 32'h4000_0021);
        rd(12'h178, 32'h8000_01a0);
        for (k = 0; k < 40; k++)
        begin
            lfsr = nx(lfsr);
            sh = lfsr & 32'hc000_bfe0;
            serdes_mode = k[0] | k[3];
            want = lfsr[7];
            wr(12'h178, sh);
            chk("restart", 32'(sh[31]), 32'(an_restart));
            @(negedge clk);
            chk("word", 32'(sh[15:0]), 32'(tx_config_word));
            chk("kind", 32'(ek(sh, serdes_mode, want)), 32'(tx_kind));
            rd(12'h178, sh);
        end
        // Regain of sync restarts only while enabled
        for (int e = 1; e >= 0; e--)
        begin
            serdes_mode = e[0];
            wr(12'h178, {e[0], 31'h0});
            drop = 1;
            repeat (3) @(negedge clk);
            drop = 0;
            k = 0;
            repeat (4)
            begin
                @(negedge clk);
                k += 32'(an_restart);
            end
            chk("resync", 32'(e), 32'(k));
        end
        conclude();
    end
endmodule : atc_top_tb_top
